// *** ctrl_sig_pkg.sv ***
// Constants and types shared by both ends of the control signal link
package ctrl_sig_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MS_CYC = CLK_HZ / 1000;
  // Times in milliseconds as documented
  localparam int unsigned IGN_MIN_MS = 100;
  localparam int unsigned IGN_CHG_MS = 1000;
  localparam int unsigned EMERG_MIN_MS = 3200;
  localparam int unsigned BLINK_MS = 600;
  localparam int unsigned SHORT_MS = 75;
  localparam int unsigned LONG_OFF_MS = 3000;
  localparam int unsigned FLASH_MS = 500;
  localparam int unsigned RING_LOW_MS = 1000;
  localparam int unsigned RING_HIGH_MS = 4000;
  localparam int unsigned REPORT_MS = 1000;
  localparam int unsigned WDOG_MS = 500;
  localparam int CW = 32;
  // Device status codes for the LED coding
  typedef enum logic [2:0] {
    ST_OFF, ST_SEARCH, ST_REGISTERED, ST_PDP_ACTIVE, ST_PDP_XFER, ST_CALL
  } dev_status_t;
  // Ring request kinds
  typedef enum logic [1:0] {
    RING_NONE, RING_VOICE, RING_DATA, RING_WAITING
  } ring_kind_t;
  localparam logic [1:0] SYNC_MODE_TX = 2'h0;
  localparam logic [1:0] SYNC_MODE_LED = 2'h1;
  // Host register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_IGN_LEN = 4'h2;
  localparam logic [3:0] REG_EMERG_LEN = 4'h3;
  localparam int CTRL_IGN = 0;
  localparam int CTRL_EMERG = 1;
  localparam int CTRL_CHARGER = 2;
endpackage

// *** ctrl_sig_if.sv ***
// Interface carrying the control pins between host and device
`timescale 1ns/1ps
interface ctrl_sig_if;
  logic powerOnTriggerNOut;
  logic powerOnTriggerNOe;
  logic emergencyPowerDownNOut;
  logic emergencyPowerDownNOe;
  logic watchdogOut;
  logic watchdogOe;
  logic burstIndicator;
  logic ringIndicatorN;
  logic hostSerialReceive;
  // Open-drain wires: pulled up unless someone drives low
  logic powerOnTriggerN;
  logic emergencyPowerDownLine;
  assign powerOnTriggerN = !(powerOnTriggerNOe && !powerOnTriggerNOut);
  assign emergencyPowerDownLine = !((emergencyPowerDownNOe &&
    !emergencyPowerDownNOut) || (watchdogOe && !watchdogOut));
  modport device (
    input powerOnTriggerN,
    input emergencyPowerDownLine,
    output watchdogOut,
    output watchdogOe,
    output burstIndicator,
    output ringIndicatorN,
    output hostSerialReceive
  );
  modport host (
    output powerOnTriggerNOut,
    output powerOnTriggerNOe,
    output emergencyPowerDownNOut,
    output emergencyPowerDownNOe,
    input emergencyPowerDownLine,
    input burstIndicator,
    input ringIndicatorN,
    input hostSerialReceive
  );
endinterface

// *** low_timer.sv ***
// Counts consecutive cycles that an input stays low
`timescale 1ns/1ps
module low_timer
  import ctrl_sig_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic lineN,
  output logic [CW-1:0] lowCount,
  output logic fell
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic prev;
  } lt_state_t;
  lt_state_t s_reg, s_next;
  always_comb begin
    s_next = s_reg;
    s_next.prev = lineN;
    if (lineN) begin
      s_next.cnt = '0;
    end else if (s_reg.cnt != '1) begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= '{cnt: '0, prev: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end
  assign lowCount = s_reg.cnt;
  assign fell = s_reg.prev && !lineN;
endmodule // low_timer

// *** ctrl_sig_device.sv ***
// Device end: power control inputs, burst/LED indicator and ring line
`timescale 1ns/1ps
module ctrl_sig_device
  import ctrl_sig_pkg::*;
#(
  parameter int unsigned IGN_CYC = IGN_MIN_MS * MS_CYC,
  parameter int unsigned EMERG_CYC = EMERG_MIN_MS * MS_CYC,
  parameter int unsigned BLINK_CYC = BLINK_MS * MS_CYC,
  parameter int unsigned SHORT_CYC = SHORT_MS * MS_CYC,
  parameter int unsigned LONG_OFF_CYC = LONG_OFF_MS * MS_CYC,
  parameter int unsigned FLASH_CYC = FLASH_MS * MS_CYC,
  parameter int unsigned RING_LOW_CYC = RING_LOW_MS * MS_CYC,
  parameter int unsigned RING_HIGH_CYC = RING_HIGH_MS * MS_CYC,
  parameter int unsigned REPORT_CYC = REPORT_MS * MS_CYC,
  parameter int unsigned WDOG_CYC = WDOG_MS * MS_CYC
) (
  input wire logic clk,
  input wire logic srst,
  ctrl_sig_if.device link,
  input wire logic [1:0] indicatorMode,
  input wire logic txBurst,
  input wire dev_status_t devStatus,
  input wire logic packetExchanged,
  input wire ring_kind_t ringKind,
  input wire logic reportEvent,
  input wire logic [3:0] functionalityLevel,
  output logic poweredOn,
  output logic sleepWake,
  output logic ringStringPulse
);
  typedef struct packed {
    logic on;
    logic armIgn;
    logic [CW-1:0] ledCnt;
    logic [1:0] ledPhase;
    logic [CW-1:0] flashCnt;
    logic [CW-1:0] flashDelay;
    logic flashPend;
    logic [CW-1:0] ringCnt;
    logic [CW-1:0] repCnt;
    logic [CW-1:0] wdCnt;
    logic wd;
    logic ind;
    logic ringN;
    logic rs;
    logic wake;
  } dev_state_t;
  dev_state_t s_reg, s_next;
  logic [CW-1:0] ignLow, emLow;
  logic ignFell;
  logic ringActive;
  low_timer ignTimer (
    .clk(clk),
    .srst(srst),
    .lineN(link.powerOnTriggerN),
    .lowCount(ignLow),
    .fell(ignFell)
  );
  low_timer emTimer (
    .clk(clk),
    .srst(srst),
    .lineN(link.emergencyPowerDownLine),
    .lowCount(emLow),
    .fell()
  );
  always_comb begin
    s_next = s_reg;
    s_next.rs = 1'b0;
    s_next.wake = 1'b0;
    // A high (open) line leaves state untouched
    if (ignFell) begin
      s_next.armIgn = 1'b1;
    end
    if (s_reg.armIgn && ignLow == IGN_CYC) begin
      s_next.on = 1'b1;
      s_next.armIgn = 1'b0;
    end
    // Watchdog pulses are far shorter than the shutdown hold
    if (emLow == EMERG_CYC) begin
      s_next.on = 1'b0;
      s_next.armIgn = 1'b0;
    end
    // Watchdog activity visible on the emergency line
    if (s_reg.on) begin
      if (s_reg.wdCnt == WDOG_CYC - 1) begin
        s_next.wdCnt = '0;
        s_next.wd = !s_reg.wd;
      end else begin
        s_next.wdCnt = s_reg.wdCnt + 1'b1;
      end
    end else begin
      s_next.wd = 1'b1;
      s_next.wdCnt = '0;
    end
    // LED pattern phase counter
    s_next.ledCnt = s_reg.ledCnt + 1'b1;
    if (packetExchanged && !s_reg.flashPend && s_reg.flashCnt == '0) begin
      s_next.flashPend = 1'b1;
      s_next.flashDelay = '0;
    end
    if (s_reg.flashPend) begin
      s_next.flashPend = 1'b0;
      s_next.flashCnt = FLASH_CYC;
    end else if (s_reg.flashCnt != '0) begin
      s_next.flashCnt = s_reg.flashCnt - 1'b1;
    end
    unique case (devStatus)
      ST_SEARCH: begin
        if (s_reg.ledCnt >= BLINK_CYC - 1) begin
          s_next.ledCnt = '0;
          s_next.ledPhase = {1'b0, !s_reg.ledPhase[0]};
        end
      end
      ST_REGISTERED: begin
        if (s_reg.ledPhase == 2'h0 && s_reg.ledCnt >= SHORT_CYC - 1 ||
            s_reg.ledPhase != 2'h0 && s_reg.ledCnt >= LONG_OFF_CYC - 1) begin
          s_next.ledCnt = '0;
          s_next.ledPhase = (s_reg.ledPhase == 2'h0) ? 2'h3 : 2'h0;
        end
      end
      ST_PDP_ACTIVE, ST_PDP_XFER: begin
        if (s_reg.ledPhase != 2'h3 && s_reg.ledCnt >= SHORT_CYC - 1 ||
            s_reg.ledPhase == 2'h3 && s_reg.ledCnt >= LONG_OFF_CYC - 1) begin
          s_next.ledCnt = '0;
          s_next.ledPhase = s_reg.ledPhase + 2'h1;
        end
      end
      default: begin
        s_next.ledCnt = '0;
        s_next.ledPhase = 2'h0;
      end
    endcase
    // Indicator output
    if (indicatorMode == SYNC_MODE_TX) begin
      s_next.ind = s_reg.on && txBurst;
    end else if (!s_reg.on) begin
      s_next.ind = 1'b0;
    end else begin
      unique case (devStatus)
        ST_SEARCH: s_next.ind = !s_reg.ledPhase[0];
        ST_REGISTERED: s_next.ind = s_reg.ledPhase == 2'h0;
        ST_PDP_ACTIVE: s_next.ind = !s_reg.ledPhase[0];
        ST_PDP_XFER: s_next.ind = s_reg.flashCnt != '0 ||
          (!s_reg.ledPhase[0] && s_reg.ledPhase != 2'h2);
        ST_CALL: s_next.ind = 1'b1;
        default: s_next.ind = 1'b0;
      endcase
    end
    // Ring indicator
    if (reportEvent && s_reg.on) begin
      s_next.repCnt = REPORT_CYC;
      s_next.rs = 1'b1;
    end else if (s_reg.repCnt != '0) begin
      s_next.repCnt = s_reg.repCnt - 1'b1;
    end
    if (ringKind == RING_VOICE || ringKind == RING_DATA) begin
      if (s_reg.ringCnt >= RING_LOW_CYC + RING_HIGH_CYC - 1) begin
        s_next.ringCnt = '0;
      end else begin
        s_next.ringCnt = s_reg.ringCnt + 1'b1;
      end
      if (s_reg.ringCnt == '0) begin
        s_next.rs = 1'b1;
      end
    end else begin
      s_next.ringCnt = '0;
    end
    unique case (ringKind)
      RING_VOICE: ringActive = s_reg.ringCnt < RING_LOW_CYC;
      RING_DATA: ringActive = 1'b1;
      RING_WAITING: ringActive = 1'b1;
      default: ringActive = 1'b0;
    endcase
    ringActive = s_reg.on && (ringActive || s_reg.repCnt != '0);
    s_next.ringN = !ringActive;
    // Wake on a new ring assertion from sleep levels
    if (s_reg.ringN && !s_next.ringN) begin
      s_next.wake = functionalityLevel == 4'h0 ||
        functionalityLevel == 4'h5 || functionalityLevel == 4'h6;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.wd <= 1'b1;
      s_reg.ringN <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end
  assign link.watchdogOut = s_reg.wd;
  assign link.watchdogOe = !s_reg.wd;
  assign link.burstIndicator = s_reg.ind;
  assign link.ringIndicatorN = s_reg.ringN;
  assign link.hostSerialReceive = !s_reg.rs;
  assign poweredOn = s_reg.on;
  // Levels 7/8 never latch wake, so saving resumes after the event
  assign sleepWake = s_reg.wake;
  assign ringStringPulse = s_reg.rs;
endmodule // ctrl_sig_device

// *** ctrl_sig_host.sv ***
// Host end: drives trigger/shutdown pulses, watches indicator and ring
`timescale 1ns/1ps
module ctrl_sig_host
  import ctrl_sig_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  ctrl_sig_if.host link,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic ringIrq
);
  typedef struct packed {
    logic [CW-1:0] ignLen;
    logic [CW-1:0] emLen;
    logic [CW-1:0] ignCnt;
    logic [CW-1:0] emCnt;
    logic charger;
    logic ringPrev;
    logic ringFell;
    logic [31:0] rd;
  } host_state_t;
  host_state_t s_reg, s_next;
  logic [CW-1:0] ignMin;
  always_comb begin
    s_next = s_reg;
    s_next.ringPrev = link.ringIndicatorN;
    ignMin = s_reg.charger ? IGN_CHG_MS * MS_CYC : IGN_MIN_MS * MS_CYC;
    if (s_reg.ignCnt != '0) begin
      s_next.ignCnt = s_reg.ignCnt - 1'b1;
    end
    if (s_reg.emCnt != '0) begin
      s_next.emCnt = s_reg.emCnt - 1'b1;
    end
    // Falling edge of the ring line
    if (s_reg.ringPrev && !link.ringIndicatorN) begin
      s_next.ringFell = 1'b1;
    end else if (rd && addr == REG_STAT) begin
      s_next.ringFell = 1'b0;
    end
    s_next.rd = '0;
    if (rd) begin
      unique case (addr)
        REG_STAT: s_next.rd = {27'h0, s_reg.ringFell,
          link.ringIndicatorN, link.burstIndicator,
          s_reg.emCnt != '0, s_reg.ignCnt != '0};
        REG_IGN_LEN: s_next.rd = s_reg.ignLen;
        REG_EMERG_LEN: s_next.rd = s_reg.emLen;
        default: s_next.rd = '0;
      endcase
    end
    if (wr) begin
      unique case (addr)
        REG_CTRL: begin
          s_next.charger = wdata[CTRL_CHARGER];
          if (wdata[CTRL_IGN]) begin
            s_next.ignCnt = (s_reg.ignLen > ignMin) ? s_reg.ignLen
              : ignMin;
          end
          if (wdata[CTRL_EMERG]) begin
            s_next.emCnt = (s_reg.emLen > EMERG_MIN_MS * MS_CYC) ?
              s_reg.emLen : EMERG_MIN_MS * MS_CYC;
          end
        end
        REG_IGN_LEN: s_next.ignLen = wdata;
        REG_EMERG_LEN: s_next.emLen = wdata;
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.ringPrev <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end
  // Open-drain: enable only while pulling low
  assign link.powerOnTriggerNOut = 1'b0;
  assign link.powerOnTriggerNOe = s_reg.ignCnt != '0;
  assign link.emergencyPowerDownNOut = 1'b0;
  assign link.emergencyPowerDownNOe = s_reg.emCnt != '0;
  assign rdata = s_reg.rd;
  assign ringIrq = s_reg.ringFell;
endmodule // ctrl_sig_host

// *** ctrl_sig_props.sv ***
// Assertions on the link between host end and device end
`timescale 1ns/1ps
module ctrl_sig_props
  import ctrl_sig_pkg::*;
#(
  parameter int unsigned IGN_CYC = 10,
  parameter int unsigned EMERG_CYC = 40,
  parameter int unsigned RING_LOW_CYC = 20
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic powerOnTriggerN,
  input wire logic emergencyPowerDownLine,
  input wire logic watchdogOe,
  input wire logic burstIndicator,
  input wire logic ringIndicatorN,
  input wire logic hostSerialReceive,
  input wire logic poweredOn,
  input wire logic txBurst,
  input wire logic [1:0] indicatorMode,
  input wire ring_kind_t ringKind
);
  int unsigned trigLow_reg;
  int unsigned emLow_reg;
  int unsigned ringLow_reg;
  // Runs of consecutive low samples
  always_ff @(posedge clk) begin
    if (srst) begin
      trigLow_reg <= 0;
      emLow_reg <= 0;
      ringLow_reg <= 0;
    end else begin
      trigLow_reg <= powerOnTriggerN ? 0 : trigLow_reg + 1;
      emLow_reg <= emergencyPowerDownLine ? 0 : emLow_reg + 1;
      ringLow_reg <= ringIndicatorN ? 0 : ringLow_reg + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  pow_early_a: assert property ($rose(poweredOn) |->
    trigLow_reg >= IGN_CYC) else $error("power-up too early");
  pow_late_a: assert property (trigLow_reg == IGN_CYC + 3 |->
    poweredOn) else $error("no power-up after trigger");
  shut_len_a: assert property ($fell(poweredOn) |->
    emLow_reg >= EMERG_CYC) else $error("power-down too early");
  off_quiet_a: assert property (!poweredOn &&
    !$past(poweredOn) |-> !burstIndicator && ringIndicatorN && !watchdogOe)
    else $error("outputs active while off");
  sync_follow_a: assert property (poweredOn &&
    $past(poweredOn) && indicatorMode == SYNC_MODE_TX &&
    $past(indicatorMode) == SYNC_MODE_TX
    |-> burstIndicator == $past(txBurst)) else $error("sync wrong");
  voice_low_a: assert property ($rose(ringIndicatorN) &&
    ringKind == RING_VOICE |-> ringLow_reg == RING_LOW_CYC)
    else $error("voice ring low time wrong");
  ring_held_a: assert property ((poweredOn &&
    ringKind inside {RING_DATA, RING_WAITING}) [*3] |-> !ringIndicatorN)
    else $error("ring not held low");
  string_pulse_a: assert property (!hostSerialReceive |=>
    hostSerialReceive) else $error("ring string marker too long");
endmodule // ctrl_sig_props

// *** tb_module_control_status_signals.sv ***
// Testbench joining host end and device end
`timescale 1ns/1ps
module tb_module_control_status_signals;
  import ctrl_sig_pkg::*;
  localparam int unsigned IGN = 10, EMG = 40, BLK = 12, SHT = 5;
  localparam int unsigned LNG = 30, RLO = 20, RHI = 30, REP = 12;
  logic clk, srst, txBurst, reportEvent, wr, rd, ringIrq, poweredOn;
  logic sleepWake, packetExchanged, ringString;
  logic [1:0] indicatorMode;
  logic [3:0] addr, functionalityLevel;
  logic [31:0] wdata, rdata;
  dev_status_t devStatus;
  ring_kind_t ringKind;
  int miscompares, comparisons, cycles, wakes, strings, hi, lo, wdLows;
  ctrl_sig_if link();
  ctrl_sig_device #(.IGN_CYC(IGN), .EMERG_CYC(EMG), .BLINK_CYC(BLK),
    .SHORT_CYC(SHT), .LONG_OFF_CYC(LNG), .FLASH_CYC(15), .RING_LOW_CYC(RLO),
    .RING_HIGH_CYC(RHI), .REPORT_CYC(REP), .WDOG_CYC(16)) i_ctrl_sig_device (
    .clk(clk), .srst(srst), .link(link), .indicatorMode(indicatorMode),
    .txBurst(txBurst), .devStatus(devStatus),
    .packetExchanged(packetExchanged), .ringKind(ringKind),
    .reportEvent(reportEvent), .functionalityLevel(functionalityLevel),
    .poweredOn(poweredOn), .sleepWake(sleepWake),
    .ringStringPulse(ringString));
  ctrl_sig_host i_ctrl_sig_host (.clk(clk), .srst(srst), .link(link),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ringIrq(ringIrq));
  ctrl_sig_props #(.IGN_CYC(IGN), .EMERG_CYC(EMG), .RING_LOW_CYC(RLO))
  i_ctrl_sig_props (.clk(clk), .srst(srst),
    .powerOnTriggerN(link.powerOnTriggerN),
    .emergencyPowerDownLine(link.emergencyPowerDownLine),
    .watchdogOe(link.watchdogOe), .burstIndicator(link.burstIndicator),
    .ringIndicatorN(link.ringIndicatorN),
    .hostSerialReceive(link.hostSerialReceive), .poweredOn(poweredOn),
    .txBurst(txBurst), .indicatorMode(indicatorMode), .ringKind(ringKind));
  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, e);
  endtask
  function automatic logic act(input bit sel);
    return sel ? !link.ringIndicatorN : link.burstIndicator;
  endfunction
  // Active then idle run lengths of indicator (0) or ring line (1)
  task automatic measure(input bit sel);
    hi = 0;
    lo = 0;
    #1;
    while (act(sel) !== 1'b1 && lo < 200) begin
      @(posedge clk);
      #1 lo++;
    end
    lo = 0;
    while (act(sel) === 1'b1 && hi < 200) begin
      @(posedge clk);
      #1 hi++;
    end
    while (act(sel) !== 1'b1 && lo < 200) begin
      @(posedge clk);
      #1 lo++;
    end
  endtask
  task automatic led(input dev_status_t s, input int h, input int l);
    @(posedge clk);
    devStatus <= s;
    measure(1'b0);
    measure(1'b0);
    check(hi, h);
    check(lo, l);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    wakes += 32'(sleepWake);
    wdLows += 32'(poweredOn && !link.emergencyPowerDownLine);
    if (!srst) strings += 32'(ringString);
    if (ringString) check(32'(link.hostSerialReceive), 32'h0);
    if (cycles == 30000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    {srst, txBurst, reportEvent, wr, rd, packetExchanged} = 6'h20;
    {indicatorMode, addr, functionalityLevel, wdata} = '0;
    devStatus = ST_OFF;
    ringKind = RING_NONE;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rd_chk(REG_STAT, 32'h8);
    rd_chk(4'hf, 32'h0);
    @(posedge clk);
    txBurst <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check(32'(link.burstIndicator), 32'h0);
    wr_reg(REG_CTRL, 32'h5);
    repeat (IGN - 2) @(posedge clk);
    #1 check(32'(poweredOn), 32'h0);
    repeat (8) @(posedge clk);
    #1 check(32'(poweredOn), 32'h1);
    check(32'(link.burstIndicator), 32'h1);
    @(posedge clk);
    txBurst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check(32'(link.burstIndicator), 32'h0);
    rd_chk(REG_STAT, 32'h9);
    @(posedge clk);
    indicatorMode <= SYNC_MODE_LED;
    devStatus <= ST_CALL;
    repeat (3) @(posedge clk);
    #1 check(32'(link.burstIndicator), 32'h1);
    led(ST_SEARCH, BLK, BLK);
    led(ST_REGISTERED, SHT, LNG);
    @(posedge clk);
    devStatus <= ST_PDP_ACTIVE;
    measure(1'b0);
    measure(1'b0);
    check(hi, SHT);
    check(32'(lo == SHT || lo == LNG), 32'h1);
    if (lo !== SHT) measure(1'b0);
    check(lo, SHT);
    measure(1'b0);
    check(hi, SHT);
    check(lo, LNG);
    // Flash ends in the long dark phase, so only the flash lights it
    @(posedge clk);
    devStatus <= ST_PDP_XFER;
    packetExchanged <= 1'b1;
    @(posedge clk);
    packetExchanged <= 1'b0;
    repeat (16) @(posedge clk);
    #1 check(32'(link.burstIndicator), 32'h1);
    @(posedge clk);
    #1 check(32'(link.burstIndicator), 32'h0);
    strings = 0;
    @(posedge clk);
    ringKind <= RING_VOICE;
    measure(1'b1);
    measure(1'b1);
    check(hi, RLO);
    check(lo, RHI);
    check(32'(strings > 0), 32'h1);
    check(32'(ringIrq), 32'h1);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      ringKind <= k == 0 ? RING_DATA : RING_WAITING;
      #1 strings = 0;
      repeat (60) @(posedge clk);
      #1 check(32'(link.ringIndicatorN), 32'h0);
      if (k == 0) check(32'(strings > 0), 32'h1);
    end
    @(posedge clk);
    ringKind <= RING_NONE;
    repeat (60) @(posedge clk);
    #1 check(32'(link.ringIndicatorN), 32'h1);
    for (int i = 0; i < 9; i++) begin
      wakes = 0;
      @(posedge clk);
      functionalityLevel <= 4'(i);
      reportEvent <= 1'b1;
      @(posedge clk);
      reportEvent <= 1'b0;
      measure(1'b1);
      check(hi, REP);
      check(32'(wakes), 32'(i == 0 || i == 5 || i == 6));
    end
    check(32'(wdLows > 0), 32'h1);
    wr_reg(REG_CTRL, 32'h2);
    repeat (EMG + 10) @(posedge clk);
    #1 check(32'(poweredOn), 32'h0);
    repeat (30) @(posedge clk);
    #1 check(32'(poweredOn), 32'h0);
    @(posedge clk);
    srst <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rd_chk(REG_STAT, 32'h8);
    report_and_stop();
  end
endmodule // tb_module_control_status_signals
